/* verilog/swdcu_core.sv */
/*
 * Command decoder and executor of the single-wire debug unit.
 * Assumes a CPU side that answers memory and register requests with acks
 * and reports whether it sits in active debug mode or in wait/stop.
 */
`timescale 1ns/1ns
`default_nettype none
module swdcu_core import swdcu_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // debug wire
    input wire logic debug_wire_pin_in,
    output logic debug_wire_pin_out,
    output logic debug_wire_pin_oe,
    // cpu state
    input wire logic debug_enable,
    input wire logic cpu_in_bdm,
    input wire logic cpu_low_power,
    output logic fw_window_en,
    output logic ack_on,
    // cpu run control
    output logic enter_req,
    output logic run_req,
    output logic [1:0] run_mode,
    // memory access
    output logic mem_req,
    output logic mem_we,
    output logic mem_byte,
    output logic mem_inmap,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    // cpu register access
    output logic reg_req,
    output logic reg_we,
    output logic [2:0] reg_sel,
    output logic [15:0] reg_wdata,
    input wire logic reg_ack,
    input wire logic [15:0] reg_rdata
);
    // ----------------------------------------------------------------
    // types and helpers
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_OPC = 4'b0000, ST_ADDR = 4'b0001, ST_DATA = 4'b0010,
        ST_MEM = 4'b0011, ST_REG = 4'b0100, ST_NXT_RD = 4'b0101,
        ST_NXT_WR = 4'b0110, ST_CTRL = 4'b0111, ST_GAP = 4'b1000,
        ST_ACK = 4'b1001, ST_SEND = 4'b1010
    } swdcu_state_t;

    function automatic swdcu_cls_t cls_of(input logic [7:0] op);
        swdcu_cls_t c;
        c = CL_NONE;
        case (op)
            OP_ENTER_DBG: c = CL_ENTER;
            OP_ACK_ON: c = CL_ACK_ON;
            OP_ACK_OFF: c = CL_ACK_OFF;
            8'he4, 8'hec, 8'he0, 8'he8: c = CL_HW_RD;
            8'hc4, 8'hcc, 8'hc0, 8'hc8: c = CL_HW_WR;
            OP_RD_NEXT: c = CL_RD_NEXT;
            OP_WR_NEXT: c = CL_WR_NEXT;
            8'h63, 8'h64, 8'h65, 8'h66, 8'h67: c = CL_FW_RD;
            8'h43, 8'h44, 8'h45, 8'h46, 8'h47: c = CL_FW_WR;
            OP_GO: c = CL_GO;
            OP_GO_UNTIL: c = CL_GO_UNTIL;
            OP_STEP: c = CL_STEP;
            OP_TAG_GO: c = CL_TAG_GO;
            default: c = CL_NONE;
        endcase
        return c;
    endfunction : cls_of

    function automatic logic is_fw(input swdcu_cls_t c);
        return c inside {CL_FW_RD, CL_FW_WR, CL_RD_NEXT, CL_WR_NEXT, CL_GO, CL_GO_UNTIL, CL_STEP, CL_TAG_GO};
    endfunction : is_fw

    function automatic logic is_read(input swdcu_cls_t c);
        return c inside {CL_HW_RD, CL_FW_RD, CL_RD_NEXT};
    endfunction : is_read

    // ----------------------------------------------------------------
    // wire engine
    // ----------------------------------------------------------------
    swdcu_bit_if lnk();
    swdcu_wire_phy u_phy (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pin_in(debug_wire_pin_in),
        .pin_out(debug_wire_pin_out),
        .pin_oe(debug_wire_pin_oe),
        .lnk(lnk)
    );

    swdcu_state_t st_q;
    swdcu_cls_t cls_q, cls_d;
    logic [7:0] op_q, op_d;
    logic [15:0] shift_q, addr_q, data_q, word_d;
    logic [4:0] bitn_q;
    logic [5:0] gap_q;
    logic ack_on_q, left_q, window_q, run_req_q, enter_q;
    logic [1:0] run_mode_q;
    logic word_done, op_done, gap_ok, cut_off;

    assign op_d = {shift_q[6:0], lnk.rx_bit};
    assign word_d = {shift_q[14:0], lnk.rx_bit};
    assign op_done = (st_q == ST_OPC) && lnk.rx_valid && bitn_q == CMD_LAST;
    assign word_done = lnk.rx_valid && bitn_q == WORD_LAST;
    assign gap_ok = gap_q >= ACK_GAP;
    // wait or stop drops a pending command without any acknowledge
    assign cut_off = cpu_low_power && st_q inside {ST_MEM, ST_REG, ST_NXT_RD, ST_NXT_WR, ST_CTRL};

    always_comb begin
        cls_d = cls_of(op_d);
        if (is_fw(cls_d) && !cpu_in_bdm) cls_d = CL_NONE;
        if (cls_d == CL_ENTER && !debug_enable) cls_d = CL_NONE;
    end

    // ----------------------------------------------------------------
    // command sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= ST_OPC;
            cls_q <= CL_NONE;
            op_q <= 8'h00;
            bitn_q <= 5'h00;
            shift_q <= 16'h0000;
            addr_q <= 16'h0000;
            data_q <= 16'h0000;
            left_q <= 1'b0;
        end else if (lnk.timeout && st_q inside {ST_OPC, ST_ADDR, ST_DATA, ST_SEND}) begin
            st_q <= ST_OPC;
            bitn_q <= 5'h00;
        end else if (cut_off) begin
            st_q <= ST_OPC;
            bitn_q <= 5'h00;
        end else begin
            case (st_q)
                ST_OPC: begin
                    if (lnk.rx_valid) begin
                        shift_q <= word_d;
                        bitn_q <= op_done ? 5'h00 : bitn_q + 5'h01;
                    end
                    if (op_done) begin
                        op_q <= op_d;
                        cls_q <= cls_d;
                        left_q <= 1'b0;
                        case (cls_d)
                            CL_ENTER, CL_GO, CL_GO_UNTIL, CL_STEP, CL_TAG_GO: st_q <= ST_CTRL;
                            CL_ACK_ON: st_q <= ST_GAP;
                            CL_HW_RD, CL_HW_WR: st_q <= ST_ADDR;
                            CL_FW_RD: st_q <= ST_REG;
                            CL_FW_WR, CL_WR_NEXT: st_q <= ST_DATA;
                            CL_RD_NEXT: st_q <= ST_NXT_RD;
                            default: st_q <= ST_OPC;
                        endcase
                    end
                end
                ST_ADDR: begin
                    if (lnk.rx_valid) begin
                        shift_q <= word_d;
                        bitn_q <= word_done ? 5'h00 : bitn_q + 5'h01;
                    end
                    if (word_done) begin
                        addr_q <= word_d;
                        st_q <= (cls_q == CL_HW_RD) ? ST_MEM : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (lnk.rx_valid) begin
                        shift_q <= word_d;
                        bitn_q <= word_done ? 5'h00 : bitn_q + 5'h01;
                    end
                    if (word_done) begin
                        data_q <= word_d;
                        case (cls_q)
                            CL_HW_WR: st_q <= ST_MEM;
                            CL_FW_WR: st_q <= ST_REG;
                            default: st_q <= ST_NXT_RD;
                        endcase
                    end
                end
                ST_MEM: begin
                    if (mem_ack) begin
                        if (is_read(cls_q)) data_q <= mem_rdata;
                        st_q <= ack_on_q ? ST_GAP : (is_read(cls_q) ? ST_SEND : ST_OPC);
                    end
                end
                ST_REG: begin
                    if (reg_ack) begin
                        if (is_read(cls_q)) data_q <= reg_rdata;
                        st_q <= ack_on_q ? ST_GAP : (is_read(cls_q) ? ST_SEND : ST_OPC);
                    end
                end
                ST_NXT_RD: begin
                    if (reg_ack) begin
                        addr_q <= reg_rdata + 16'h0002;
                        st_q <= ST_NXT_WR;
                    end
                end
                ST_NXT_WR: begin
                    if (reg_ack) st_q <= ST_MEM;
                end
                ST_CTRL: begin
                    if (!cpu_in_bdm) left_q <= 1'b1;
                    case (cls_q)
                        CL_ENTER: if (cpu_in_bdm) st_q <= ack_on_q ? ST_GAP : ST_OPC;
                        CL_GO: if (!cpu_in_bdm) st_q <= ack_on_q ? ST_GAP : ST_OPC;
                        CL_GO_UNTIL, CL_STEP: if (left_q && cpu_in_bdm) st_q <= ack_on_q ? ST_GAP : ST_OPC;
                        default: st_q <= ST_OPC;
                    endcase
                end
                ST_GAP: begin
                    if (gap_ok) st_q <= ST_ACK;
                end
                ST_ACK: begin
                    if (!lnk.ack_busy) begin
                        st_q <= is_read(cls_q) ? ST_SEND : ST_OPC;
                        shift_q <= data_q;
                        bitn_q <= 5'h00;
                    end
                end
                ST_SEND: begin
                    if (lnk.bit_start) begin
                        shift_q <= {shift_q[14:0], 1'b0};
                        bitn_q <= bitn_q + 5'h01;
                        if (bitn_q == WORD_LAST) begin
                            st_q <= ST_OPC;
                            bitn_q <= 5'h00;
                        end
                    end
                end
                default: st_q <= ST_OPC;
            endcase
            if (st_q == ST_MEM && mem_ack && !ack_on_q && is_read(cls_q)) shift_q <= mem_rdata;
            if (st_q == ST_REG && reg_ack && !ack_on_q && is_read(cls_q)) shift_q <= reg_rdata;
        end
    end

    // ----------------------------------------------------------------
    // handshake state and acknowledge spacing
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_on_q <= 1'b0;
        end else if (op_done && cls_d == CL_ACK_ON) begin
            ack_on_q <= 1'b1;
        end else if (op_done && cls_d == CL_ACK_OFF) begin
            ack_on_q <= 1'b0;
        end
    end
    // the host needs 32 clocks after the last bit to get off the wire
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gap_q <= 6'h00;
        end else if (lnk.rx_valid) begin
            gap_q <= 6'h00;
        end else if (!gap_ok) begin
            gap_q <= gap_q + 6'h01;
        end
    end
    assign lnk.ack_go = (st_q == ST_GAP) && gap_ok;
    assign lnk.tx_en = (st_q == ST_SEND);
    assign lnk.tx_bit = shift_q[15];

    // ----------------------------------------------------------------
    // cpu run control and window
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            run_req_q <= 1'b0;
            run_mode_q <= 2'h0;
            enter_q <= 1'b0;
            window_q <= 1'b0;
        end else begin
            run_req_q <= op_done && cls_d inside {CL_GO, CL_GO_UNTIL, CL_STEP, CL_TAG_GO};
            if (op_done) run_mode_q <= cls_d[1:0]; // go=10 until=11 step=00 tag=01
            enter_q <= (cls_d == CL_ENTER && op_done) || (enter_q && !cpu_in_bdm && st_q == ST_CTRL);
            window_q <= cpu_in_bdm;
        end
    end
    assign run_req = run_req_q;
    assign run_mode = run_mode_q;
    assign enter_req = enter_q;
    assign fw_window_en = window_q;
    assign ack_on = ack_on_q;

    // ----------------------------------------------------------------
    // memory and register requests
    // ----------------------------------------------------------------
    assign mem_req = (st_q == ST_MEM);
    assign mem_we = (cls_q == CL_HW_WR) || (cls_q == CL_WR_NEXT);
    assign mem_byte = (cls_q inside {CL_HW_RD, CL_HW_WR}) && !op_q[3];
    assign mem_inmap = mem_req && (cls_q inside {CL_HW_RD, CL_HW_WR}) && op_q[2];
    assign mem_addr = {addr_q[15:1], addr_q[0] & mem_byte};
    assign mem_wdata = data_q;
    assign reg_req = st_q inside {ST_REG, ST_NXT_RD, ST_NXT_WR};
    assign reg_we = (st_q == ST_NXT_WR) || (st_q == ST_REG && cls_q == CL_FW_WR);
    assign reg_sel = (st_q == ST_REG) ? op_q[2:0] - REG_BASE : REG_X;
    assign reg_wdata = (st_q == ST_NXT_WR) ? addr_q : data_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_enter_gated: assert property (op_done && op_d == OP_ENTER_DBG && !debug_enable |=> st_q == ST_OPC)
        else $error("enter-debug taken while disabled");
    a_ack_on_acks: assert property (op_done && op_d == OP_ACK_ON |=> ack_on_q && st_q == ST_GAP)
        else $error("ack-enable did not start acknowledge");
    a_ack_off_quiet: assert property (op_done && op_d == OP_ACK_OFF |=> !ack_on_q && st_q == ST_OPC)
        else $error("ack-disable misbehaved");
    a_word_aligned: assert property (mem_req && !mem_byte |-> !mem_addr[0])
        else $error("word access on odd address");
    a_inmap_only_req: assert property (mem_inmap == (mem_req && op_q inside {8'he4, 8'hec, 8'hc4, 8'hcc}))
        else $error("debug map selected outside access");
    a_fw_outside_mode: assert property (op_done && is_fw(cls_of(op_d)) && !cpu_in_bdm |=> st_q == ST_OPC)
        else $error("firmware opcode run outside debug mode");
    a_tag_no_ack: assert property (st_q == ST_CTRL && cls_q == CL_TAG_GO |=> st_q == ST_OPC ##1 !lnk.ack_go)
        else $error("tag-and-resume acknowledged");
    a_next_adds_two: assert property (st_q == ST_NXT_RD && reg_ack |=> addr_q == $past(reg_rdata) + 16'h0002)
        else $error("next command did not add two");
    a_low_power_drop: assert property (cut_off && !lnk.timeout |=> st_q == ST_OPC && !lnk.ack_go)
        else $error("pending command survived wait or stop");
    a_ack_spacing: assert property (lnk.ack_go |-> gap_q >= ACK_GAP && ack_on_q)
        else $error("acknowledge too early or handshake off");

    c_ack_sent: cover property (lnk.ack_go);
    c_read_sent: cover property (st_q == ST_SEND && lnk.bit_start && bitn_q == WORD_LAST);
    c_step_back: cover property (st_q == ST_CTRL && cls_q == CL_STEP && left_q && cpu_in_bdm);
endmodule : swdcu_core
`default_nettype wire

/* verilog/swdcu_pkg.sv */
/*
 * Constants, opcodes and types for the single-wire debug command unit.
 * Assumes one core clock that also serves as the serial target clock.
 */
package swdcu_pkg;
    // ----------------------------------------------------------------
    // opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_ENTER_DBG = 8'h90;
    localparam logic [7:0] OP_ACK_ON = 8'hd5;
    localparam logic [7:0] OP_ACK_OFF = 8'hd6;
    localparam logic [7:0] OP_TAG_GO = 8'h18;
    localparam logic [7:0] OP_GO = 8'h08;
    localparam logic [7:0] OP_GO_UNTIL = 8'h0c;
    localparam logic [7:0] OP_STEP = 8'h10;
    localparam logic [7:0] OP_RD_NEXT = 8'h62;
    localparam logic [7:0] OP_WR_NEXT = 8'h42;
    localparam logic [2:0] REG_BASE = 3'h3;
    localparam logic [2:0] REG_X = 3'h2;
    // ----------------------------------------------------------------
    // timing in target clocks, and last bit numbers of command and word
    // ----------------------------------------------------------------
    localparam logic [4:0] BIT_CLKS = 5'h10;
    localparam logic [4:0] SAMPLE_AT = 5'h0a;
    localparam logic [4:0] SPEED_HI_AT = 5'h07;
    localparam logic [4:0] LOW_ZERO_CLKS = 5'h0d;
    localparam logic [4:0] ACK_LOW_CLKS = 5'h10;
    localparam logic [5:0] ACK_MIN_GAP = 6'h20;
    localparam logic [5:0] ACK_GAP = ACK_MIN_GAP + 6'(BIT_CLKS - SAMPLE_AT);
    localparam logic [9:0] LINK_TIMEOUT = 10'h1ff;
    localparam logic [4:0] CMD_LAST = 5'h07;
    localparam logic [4:0] WORD_LAST = 5'h0f;

    typedef enum logic [3:0] {
        CL_NONE = 4'b0000, CL_ENTER = 4'b0001, CL_ACK_ON = 4'b0010,
        CL_ACK_OFF = 4'b0011, CL_HW_RD = 4'b0100, CL_HW_WR = 4'b0101,
        CL_FW_RD = 4'b0110, CL_FW_WR = 4'b0111, CL_RD_NEXT = 4'b1000,
        CL_WR_NEXT = 4'b1001, CL_GO = 4'b1010, CL_GO_UNTIL = 4'b1011,
        CL_STEP = 4'b1100, CL_TAG_GO = 4'b1101
    } swdcu_cls_t;
endpackage : swdcu_pkg

/* verilog/swdcu_bit_if.sv */
/*
 * Bit-level carrier between the wire engine and the command core.
 * Assumes both ends run on core_clk.
 */
`timescale 1ns/1ns
`default_nettype none
interface swdcu_bit_if;
    logic bit_start;
    logic rx_valid;
    logic rx_bit;
    logic tx_en;
    logic tx_bit;
    logic ack_go;
    logic ack_busy;
    logic timeout;
    modport phy (output bit_start, rx_valid, rx_bit, ack_busy, timeout, input tx_en, tx_bit, ack_go);
    modport core (input bit_start, rx_valid, rx_bit, ack_busy, timeout, output tx_en, tx_bit, ack_go);
endinterface : swdcu_bit_if
`default_nettype wire

/* verilog/swdcu_wire_phy.sv */
/*
 * Bit timing on the open-drain debug wire: receive, transmit, acknowledge.
 * Assumes the host starts every bit with a falling edge.
 */
`timescale 1ns/1ns
`default_nettype none
module swdcu_wire_phy import swdcu_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // debug wire
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    // core side
    swdcu_bit_if.phy lnk
);
    logic sync1_q, sync2_q, prev_q, act_q, tx_q, txb_q, ack_run_q, rxv_q, rxb_q, to_q;
    logic [4:0] cnt_q, ack_q;
    logic [9:0] idle_q;
    logic fall, low_d, hi_d;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_q <= 1'b1; sync2_q <= 1'b1; prev_q <= 1'b1;
        end else begin
            sync1_q <= pin_in; sync2_q <= sync1_q; prev_q <= sync2_q;
        end
    end
    // own drive must not look like a host edge
    assign fall = prev_q & ~sync2_q & ~pin_oe & ~ack_run_q;
    assign lnk.bit_start = fall;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            act_q <= 1'b0; tx_q <= 1'b0; txb_q <= 1'b0; cnt_q <= 5'h00;
        end else if (fall) begin
            act_q <= 1'b1; tx_q <= lnk.tx_en; txb_q <= lnk.tx_bit; cnt_q <= 5'h00;
        end else if (act_q) begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == BIT_CLKS - 5'h01) act_q <= 1'b0;
        end
    end
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rxv_q <= 1'b0; rxb_q <= 1'b0;
        end else begin
            rxv_q <= act_q & ~tx_q & (cnt_q == SAMPLE_AT - 5'h01);
            rxb_q <= sync2_q;
        end
    end
    assign lnk.rx_valid = rxv_q;
    assign lnk.rx_bit = rxb_q;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_run_q <= 1'b0; ack_q <= 5'h00;
        end else if (lnk.ack_go) begin
            ack_run_q <= 1'b1; ack_q <= 5'h00;
        end else if (ack_run_q) begin
            ack_q <= ack_q + 5'h01;
            if (ack_q == ACK_LOW_CLKS) ack_run_q <= 1'b0;
        end
    end
    assign lnk.ack_busy = ack_run_q | lnk.ack_go;
    assign low_d = (ack_run_q && ack_q < ACK_LOW_CLKS) || (act_q && tx_q && !txb_q && cnt_q < LOW_ZERO_CLKS);
    assign hi_d = (ack_run_q && ack_q == ACK_LOW_CLKS) ||
                  (act_q && tx_q && cnt_q == (txb_q ? SPEED_HI_AT : LOW_ZERO_CLKS));
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_oe <= 1'b0; pin_out <= 1'b0;
        end else begin
            pin_oe <= low_d | hi_d;
            pin_out <= hi_d;
        end
    end
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            idle_q <= 10'h000; to_q <= 1'b0;
        end else begin
            idle_q <= fall ? 10'h000 : (idle_q == LINK_TIMEOUT ? idle_q : idle_q + 10'h001);
            to_q <= (idle_q == LINK_TIMEOUT - 10'h001);
        end
    end
    assign lnk.timeout = to_q;

    a_ack_pulse_shape: assert property (@(posedge core_clk) disable iff (sys_rst)
        lnk.ack_go |-> ##2 (pin_oe && !pin_out)[*8] ##1 (pin_oe && !pin_out)[*8] ##1 (pin_oe && pin_out))
        else $error("acknowledge pulse shape wrong");
endmodule : swdcu_wire_phy
`default_nettype wire

/* sim/swdcu_host_pod.sv */
/* host pod model on the debug wire.
   assumes the bench resolves the wire from all drivers. */
`timescale 1ns/1ns
`default_nettype none
module swdcu_host_pod (
    // clock
    input wire logic core_clk,
    // wire
    input wire logic wire_lvl,
    output logic host_low
);
    // msb first, each bit opened by our falling edge, 21 clocks so the 16-clock bit always fits
    task automatic send(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge core_clk) host_low = 1'b1;
            repeat (v[i] ? 3 : 15) @(negedge core_clk);
            host_low = 1'b0;
            repeat (v[i] ? 17 : 5) @(negedge core_clk);
        end
    endtask : send
    task automatic recv(output logic [15:0] v);
        for (int i = 15; i >= 0; i--) begin
            @(negedge core_clk) host_low = 1'b1;
            repeat (2) @(negedge core_clk);
            host_low = 1'b0;
            repeat (10) @(negedge core_clk);
            v[i] = wire_lvl;
            repeat (8) @(negedge core_clk);
        end
    endtask : recv
    // 400 clocks also covers the fixed waits owed when the handshake is off
    task automatic wait_ack(output int lows);
        lows = 0;
        repeat (400) @(negedge core_clk) lows += !wire_lvl;
    endtask : wait_ack
endmodule : swdcu_host_pod
`default_nettype wire

/* sim/tb.sv */
/* bench for the debug command unit.
   assumes a one-cycle memory and register answer. */
`timescale 1ns/1ns
`default_nettype none
module tb import swdcu_pkg::*;;
    logic core_clk, sys_rst, host_low, wire_lvl, debug_enable, cpu_in_bdm, cpu_low_power, mem_ack, reg_ack;
    logic pin_out, pin_oe, enter_req, mem_req, mem_we, mem_byte, mem_inmap, reg_req, reg_we, run_req, stepping;
    logic fw_win, hs_on;
    logic [1:0] run_mode;
    logic [15:0] mem_addr, mem_wdata, cap_addr, cap_wdata, rd, reg_wdata, cap_rwd;
    logic [2:0] cap_fl, reg_sel, cap_rsel;
    int n_mismatch = 0, n_checks = 0, lows;
    assign wire_lvl = !(host_low || (pin_oe && !pin_out));
    swdcu_host_pod HOST (.core_clk(core_clk), .wire_lvl(wire_lvl), .host_low(host_low));
    swdcu_core DUT (.core_clk(core_clk), .sys_rst(sys_rst), .debug_wire_pin_in(wire_lvl),
        .debug_wire_pin_out(pin_out), .debug_wire_pin_oe(pin_oe), .debug_enable(debug_enable),
        .cpu_in_bdm(cpu_in_bdm), .cpu_low_power(cpu_low_power), .fw_window_en(fw_win), .ack_on(hs_on),
        .enter_req(enter_req), .run_req(run_req), .run_mode(run_mode), .mem_req(mem_req), .mem_we(mem_we),
        .mem_byte(mem_byte), .mem_inmap(mem_inmap), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(16'hbeef), .reg_req(reg_req), .reg_we(reg_we), .reg_sel(reg_sel),
        .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(16'h1234));
    // ----
    // cpu side responder
    // ----
    always @(negedge core_clk) begin
        mem_ack <= mem_req && !mem_ack;
        reg_ack <= reg_req && !reg_ack;
        if (enter_req) cpu_in_bdm <= 1'b1;
        // a run leaves debug mode; a single step comes back one cycle later
        if (run_req) begin
            cpu_in_bdm <= 1'b0;
            stepping <= run_mode == 2'b00;
        end else if (stepping) begin
            cpu_in_bdm <= 1'b1;
            stepping <= 1'b0;
        end
        if (reg_req && reg_we) begin
            cap_rsel <= reg_sel;
            cap_rwd <= reg_wdata;
        end
        if (mem_req) begin
            cap_addr <= mem_addr;
            cap_fl <= {mem_we, mem_byte, mem_inmap};
            cap_wdata <= mem_wdata;
        end
    end
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic cmd(input logic [7:0] op, input logic [15:0] el);
        HOST.send({8'h00, op}, 8);
        HOST.wait_ack(lows);
        chk("ack lows", el, lows[15:0]);
    endtask : cmd
    task automatic do_rd(input logic [7:0] op, input logic [15:0] a, input logic [15:0] ea, input logic [2:0] fl);
        HOST.send({8'h00, op}, 8);
        HOST.send(a, 16);
        HOST.wait_ack(lows);
        chk("read ack", 16'h0010, lows[15:0]);
        HOST.recv(rd);
        chk("read addr", ea, cap_addr);
        chk("read kind", {13'h0000, fl}, {13'h0000, cap_fl});
        chk("read data", 16'hbeef, rd);
    endtask : do_rd
    task automatic do_wr(input logic [7:0] op, input logic [15:0] a, input logic [15:0] ea, input logic [2:0] fl,
            input logic [15:0] el);
        HOST.send({8'h00, op}, 8);
        HOST.send(a, 16);
        HOST.send(16'h5a3c, 16);
        HOST.wait_ack(lows);
        chk("write ack", el, lows[15:0]);
        chk("write addr", ea, cap_addr);
        chk("write kind", {13'h0000, fl}, {13'h0000, cap_fl});
        chk("write data", 16'h5a3c, cap_wdata);
    endtask : do_wr
    task automatic t_reads;
        do_rd(8'he0, 16'h1235, 16'h1235, 3'h2);
        do_rd(8'he4, 16'h1234, 16'h1234, 3'h3);
        do_rd(8'he8, 16'h1235, 16'h1234, 3'h0);
        do_rd(8'hec, 16'hff03, 16'hff02, 3'h1);
    endtask : t_reads
    task automatic t_writes;
        do_wr(8'hc0, 16'h1001, 16'h1001, 3'h6, 16'h0010);
        do_wr(8'hc4, 16'hff01, 16'hff01, 3'h7, 16'h0010);
        do_wr(8'hc8, 16'h2003, 16'h2002, 3'h4, 16'h0010);
        do_wr(8'hcc, 16'hff05, 16'hff04, 3'h5, 16'h0010);
    endtask : t_writes
    // refused while disabled, then entered and a register read answered
    task automatic t_enter;
        cmd(OP_ENTER_DBG, 16'h0000);
        chk("enter_req", 16'h0000, {15'h0000, enter_req});
        debug_enable = 1'b1;
        cmd(OP_ENTER_DBG, 16'h0010);
        cmd(8'h63, 16'h0010);
        HOST.recv(rd);
        chk("pc read", 16'h1234, rd);
        chk("window", 16'h0001, {15'h0000, fw_win});
    endtask : t_enter
    // next commands step X by two, then a stack pointer load
    task automatic t_firmware;
        cmd(OP_RD_NEXT, 16'h0010);
        HOST.recv(rd);
        chk("next rd data", 16'hbeef, rd);
        chk("next rd addr", 16'h1236, cap_addr);
        chk("next x", 16'h1236, cap_rwd);
        HOST.send({8'h00, OP_WR_NEXT}, 8);
        HOST.send(16'hc3a5, 16);
        HOST.wait_ack(lows);
        chk("next wr ack", 16'h0010, lows[15:0]);
        chk("next wr data", 16'hc3a5, cap_wdata);
        chk("next wr kind", 16'h0004, {13'h0000, cap_fl});
        HOST.send(16'h0047, 8);
        HOST.send(16'h0f1e, 16);
        HOST.wait_ack(lows);
        chk("sp wr ack", 16'h0010, lows[15:0]);
        chk("sp wr", 16'h0f1e, cap_rwd);
        chk("sp sel", 16'h0004, {13'h0000, cap_rsel});
    endtask : t_firmware
    // step, run, tag, a run cut short by wait, then firmware refused outside debug mode
    task automatic t_run;
        cmd(OP_STEP, 16'h0010);
        cmd(OP_GO, 16'h0010);
        cmd(OP_ENTER_DBG, 16'h0010);
        cmd(OP_TAG_GO, 16'h0000);
        chk("window", 16'h0000, {15'h0000, fw_win});
        cmd(OP_ENTER_DBG, 16'h0010);
        HOST.send({8'h00, OP_GO_UNTIL}, 8);
        cpu_low_power = 1'b1;
        HOST.wait_ack(lows);
        chk("wait ack", 16'h0000, lows[15:0]);
        cpu_low_power = 1'b0;
        cmd(8'h63, 16'h0000);
    endtask : t_run
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        {host_low, debug_enable, cpu_in_bdm, cpu_low_power, mem_ack, reg_ack, stepping} = 7'h00;
        sys_rst = 1'b1;
        repeat (12) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge core_clk);
        cmd(OP_ACK_ON, 16'h0010);
        t_reads();
        t_writes();
        t_enter();
        t_firmware();
        t_run();
        cmd(OP_ACK_OFF, 16'h0000);
        chk("ack_on", 16'h0000, {15'h0000, hs_on});
        do_wr(8'hc0, 16'h3001, 16'h3001, 3'h6, 16'h0000);
        end_of_test();
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
endmodule : tb
`default_nettype wire
